/* verilog/efepc_pkg.sv */
package efepc_pkg;

	// ----------------------------------------------------------------
	// Array geometry
	// ----------------------------------------------------------------
	localparam int unsigned PAGE_BYTES      = 512;
	localparam int unsigned NUM_PAGES       = 512;
	localparam int unsigned PAGES_PER_GROUP = 8;
	localparam int unsigned NUM_GROUPS      = NUM_PAGES / PAGES_PER_GROUP;
	localparam int unsigned WORD_AW         = 16;
	localparam int unsigned NUM_WORDS       = 65536;
	localparam int unsigned PAGE_WORDS      = PAGE_BYTES / 4;
	localparam logic [31:0] ERASED_WORD     = 32'hffff_ffff;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	localparam logic [13:0] FLASH_REGION = 14'h0000;
	localparam logic [23:0] REG_REGION   = 24'h00_0400;
	localparam logic [7:0]  OFS_MAIN     = 8'h00;
	localparam logic [7:0]  OFS_TIMING   = 8'h04;
	localparam logic [7:0]  OFS_LOCK0    = 8'h08;
	localparam logic [7:0]  OFS_LOCK1    = 8'h0c;
	localparam logic [7:0]  OFS_LOCK2    = 8'h10;
	localparam logic [7:0]  OFS_LOCK3    = 8'h14;
	localparam logic [7:0]  OFS_IER      = 8'h18;
	localparam logic [7:0]  OFS_FLAG     = 8'h1c;
	localparam logic [7:0]  OFS_CLEAR    = 8'h20;

	// ----------------------------------------------------------------
	// Fields, codes and reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] WR_KEY        = 16'h5a5a;
	localparam logic [1:0]  MODE_READ     = 2'h0;
	localparam logic [1:0]  MODE_PROGRAM_ERROR_FLAG     = 2'h1;
	localparam logic [1:0]  MODE_ERASE    = 2'h2;
	localparam int unsigned MAIN_BUSY_BIT = 4;
	localparam int unsigned FLG_LOCK      = 0;
	localparam int unsigned FLG_PROGRAM_ERROR_FLAG      = 1;
	localparam int unsigned FLG_PC        = 2;
	localparam logic [2:0]  CLEAR_READ    = 3'h7;
	localparam logic [1:0]  MODE_RST      = 2'h0;
	localparam logic [2:0]  WAIT_RST      = 3'h0;
	localparam logic [63:0] LOCK_RST      = 64'h0;
	localparam logic [2:0]  IER_RST       = 3'h0;
	localparam logic [2:0]  HSIZE_BYTE    = 3'h0;
	localparam logic [2:0]  HSIZE_HALF    = 3'h1;
	localparam logic [2:0]  HSIZE_WORD    = 3'h2;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned PROGRAM_ERROR_FLAG_TIME_NS  = 20000;
	localparam int unsigned PROGRAM_ERROR_FLAG_CYCLES   = (PROGRAM_ERROR_FLAG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ERASE_TIME_US = 4000;
	localparam int unsigned ERASE_CYCLES_DEF = (ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// State types
	// ----------------------------------------------------------------
	typedef enum logic [3:0]
	{
		BS_IDLE = 4'b0001,
		BS_RD   = 4'b0010,
		BS_RDW  = 4'b0100,
		BS_ERR  = 4'b1000
	} efepc_bus_e;

	typedef enum logic [4:0]
	{
		OP_IDLE  = 5'b00001,
		OP_CHECK = 5'b00010,
		OP_PROGRAM_ERROR_FLAG  = 5'b00100,
		OP_ERASE = 5'b01000,
		OP_HOLD  = 5'b10000
	} efepc_op_e;

endpackage : efepc_pkg

/* verilog/efepc_mem.sv */
module efepc_mem
	import efepc_pkg::*;
(
	// Clock
	input  wire logic                CLK_SYS,
	// Access
	input  wire logic [WORD_AW-1:0]  addr,
	input  wire logic                we,
	input  wire logic [31:0]         wdata,
	output logic      [31:0]         rdata
);

	logic [31:0] cells [NUM_WORDS];

	// ----------------------------------------------------------------
	// Registered read, word write
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS)
	begin
		if (we)
		begin
			cells[addr] <= wdata;
		end
		rdata <= cells[addr];
	end

endmodule : efepc_mem

/* verilog/efepc_top.sv */
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
module efepc_top
	import efepc_pkg::*;
#(
	parameter int unsigned ERASE_CYCLES = ERASE_CYCLES_DEF
)
(
	// Clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        RST,
	// AHB-Lite slave
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	// Core execution state
	input  wire logic [31:0] PC_ADDR,
	input  wire logic        PC_IN_FLASH,
	// Interrupt
	output logic             IRQ_FLASH
);

	efepc_bus_e         bus_r;
	efepc_op_e          op_r;
	logic [31:0]        dp_addr_r, op_data_r, hrdata_r, mem_wdata, mem_q, reg_rdata, be_mask;
	logic [2:0]         dp_size_r, wait_r, ier_r, flag_r, rd_cnt_r, flag_set, flag_clr;
	logic [1:0]         mode_r;
	logic [63:0]        lock_r;
	logic [23:0]        tmr_r;
	logic [WORD_AW-1:0] op_addr_r, mem_addr;
	logic [3:0]         op_be_r, dp_be;
	logic [8:0]         dp_page;
	logic               dp_fl_wr_r, dp_reg_wr_r, irq_r, hreadyout_r, hresp_r, mem_we;
	logic               accept, misalign, is_flash, is_reg, busy, active, unlocked;
	logic               pc_hit, lock_fail, pc_fail, program_error_flag_fail, start, key_ok;

	// ----------------------------------------------------------------
	// Address phase decode
	// ----------------------------------------------------------------
	assign accept   = HSEL && HTRANS[1] && HREADY && (bus_r == BS_IDLE);
	assign is_flash = (HADDR[31:18] == FLASH_REGION);
	assign is_reg   = (HADDR[31:8] == REG_REGION);
	assign misalign = ((HSIZE == HSIZE_HALF) && HADDR[0])
	               || ((HSIZE == HSIZE_WORD) && (HADDR[1:0] != 2'h0))
	               || (HSIZE > HSIZE_WORD);
	assign busy     = (op_r != OP_IDLE);
	assign key_ok   = (HWDATA[31:16] == WR_KEY);

	always_comb
	begin
		case (HADDR[7:0])
			OFS_MAIN:   reg_rdata = {27'h0, busy, 2'h0, mode_r};
			OFS_TIMING: reg_rdata = {29'h0, wait_r};
			OFS_LOCK0:  reg_rdata = {16'h0, lock_r[15:0]};
			OFS_LOCK1:  reg_rdata = {16'h0, lock_r[31:16]};
			OFS_LOCK2:  reg_rdata = {16'h0, lock_r[47:32]};
			OFS_LOCK3:  reg_rdata = {16'h0, lock_r[63:48]};
			OFS_IER:    reg_rdata = {29'h0, ier_r};
			OFS_FLAG:   reg_rdata = {29'h0, flag_r};
			OFS_CLEAR:  reg_rdata = {29'h0, CLEAR_READ};
			default:    reg_rdata = 32'h0;
		endcase
	end

	// ----------------------------------------------------------------
	// Bus data phase
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			bus_r       <= BS_IDLE;
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
			hrdata_r    <= 32'h0;
			rd_cnt_r    <= 3'h0;
			dp_addr_r   <= 32'h0;
			dp_size_r   <= 3'h0;
			dp_fl_wr_r  <= 1'b0;
			dp_reg_wr_r <= 1'b0;
		end
		else
		begin
			case (bus_r)
				BS_IDLE:
				begin
					dp_fl_wr_r  <= 1'b0;
					dp_reg_wr_r <= 1'b0;
					hresp_r     <= 1'b0;
					if (accept)
					begin
						dp_addr_r <= HADDR;
						dp_size_r <= HSIZE;
						if (misalign)
						begin
							bus_r       <= BS_ERR;
							hresp_r     <= 1'b1;
							hreadyout_r <= 1'b0;
						end
						else if (HWRITE)
						begin
							dp_fl_wr_r  <= is_flash;
							dp_reg_wr_r <= is_reg;
						end
						else if (is_flash)
						begin
							bus_r       <= BS_RD;
							hreadyout_r <= 1'b0;
						end
						else
							hrdata_r <= is_reg ? reg_rdata : 32'h0;
					end
				end
				BS_ERR:
				begin
					hreadyout_r <= 1'b1;
					bus_r       <= BS_IDLE;
				end
				BS_RD:
				begin
					// Fetches wait here for the whole erase or program.
					if (!busy)
					begin
						rd_cnt_r <= wait_r;
						bus_r    <= BS_RDW;
					end
				end
				BS_RDW:
				begin
					if (rd_cnt_r == 3'h0)
					begin
						hrdata_r    <= mem_q;
						hreadyout_r <= 1'b1;
						bus_r       <= BS_IDLE;
					end
					else
						rd_cnt_r <= rd_cnt_r - 3'h1;
				end
				default:
				begin
					bus_r       <= BS_IDLE;
					hreadyout_r <= 1'b1;
					hresp_r     <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			mode_r <= MODE_RST;
			wait_r <= WAIT_RST;
			lock_r <= LOCK_RST;
			ier_r  <= IER_RST;
		end
		else if (dp_reg_wr_r)
		begin
			case (dp_addr_r[7:0])
				OFS_MAIN:   if (key_ok) mode_r <= HWDATA[1:0];
				OFS_TIMING: wait_r <= HWDATA[2:0];
				OFS_LOCK0:  if (key_ok) lock_r[15:0] <= HWDATA[15:0];
				OFS_LOCK1:  if (key_ok) lock_r[31:16] <= HWDATA[15:0];
				OFS_LOCK2:  if (key_ok) lock_r[47:32] <= HWDATA[15:0];
				OFS_LOCK3:  if (key_ok) lock_r[63:48] <= HWDATA[15:0];
				OFS_IER:    ier_r <= HWDATA[2:0];
				default:    ier_r <= ier_r;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Flash write screening
	// ----------------------------------------------------------------
	assign dp_page  = dp_addr_r[17:9];
	assign unlocked = lock_r[dp_page[8:3]];
	assign pc_hit   = PC_IN_FLASH && (PC_ADDR[31:18] == FLASH_REGION) && (PC_ADDR[17:9] == dp_page);
	// A write that lands while busy is dropped; software must poll first.
	assign active   = dp_fl_wr_r && !busy && ((mode_r == MODE_PROGRAM_ERROR_FLAG) || (mode_r == MODE_ERASE));
	assign lock_fail = active && !unlocked;
	assign pc_fail   = active && unlocked && pc_hit;
	assign start     = active && unlocked && !pc_hit;

	always_comb
	begin
		case (dp_size_r)
			HSIZE_BYTE: dp_be = 4'(4'h1 << dp_addr_r[1:0]);
			HSIZE_HALF: dp_be = dp_addr_r[1] ? 4'hc : 4'h3;
			default:    dp_be = 4'hf;
		endcase
	end

	assign be_mask   = {{8{op_be_r[3]}}, {8{op_be_r[2]}}, {8{op_be_r[1]}}, {8{op_be_r[0]}}};
	assign program_error_flag_fail = (op_r == OP_PROGRAM_ERROR_FLAG) && ((mem_q & be_mask) != be_mask);

	// ----------------------------------------------------------------
	// Erase and program engine
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			op_r      <= OP_IDLE;
			op_addr_r <= '0;
			op_data_r <= 32'h0;
			op_be_r   <= 4'h0;
			tmr_r     <= 24'h0;
		end
		else
		begin
			case (op_r)
				OP_IDLE:
				begin
					if (start && (mode_r == MODE_ERASE))
					begin
						op_addr_r <= {dp_page, 7'h0};
						op_r      <= OP_ERASE;
					end
					else if (start)
					begin
						op_addr_r <= dp_addr_r[17:2];
						op_data_r <= HWDATA;
						op_be_r   <= dp_be;
						op_r      <= OP_CHECK;
					end
				end
				OP_CHECK: op_r <= OP_PROGRAM_ERROR_FLAG;
				OP_PROGRAM_ERROR_FLAG:
				begin
					tmr_r <= 24'(PROGRAM_ERROR_FLAG_CYCLES - 3);
					op_r  <= program_error_flag_fail ? OP_IDLE : OP_HOLD;
				end
				OP_ERASE:
				begin
					op_addr_r <= op_addr_r + 16'h1;
					if (op_addr_r[6:0] == 7'h7f)
					begin
						tmr_r <= 24'(ERASE_CYCLES - 129);
						op_r  <= OP_HOLD;
					end
				end
				OP_HOLD:
				begin
					tmr_r <= tmr_r - 24'h1;
					if (tmr_r == 24'h0)
						op_r <= OP_IDLE;
				end
				default: op_r <= OP_IDLE;
			endcase
		end
	end

	assign mem_addr  = busy ? op_addr_r : dp_addr_r[17:2];
	assign mem_we    = (op_r == OP_ERASE) || ((op_r == OP_PROGRAM_ERROR_FLAG) && !program_error_flag_fail);
	// Merging by AND keeps programming from ever raising a cleared bit.
	assign mem_wdata = (op_r == OP_ERASE) ? ERASED_WORD : (mem_q & (op_data_r | ~be_mask));

	efepc_mem u_mem
	(
		.CLK_SYS (CLK_SYS),
		.addr    (mem_addr),
		.we      (mem_we),
		.wdata   (mem_wdata),
		.rdata   (mem_q)
	);

	// ----------------------------------------------------------------
	// Failure flags and interrupt
	// ----------------------------------------------------------------
	assign flag_set = {pc_fail, program_error_flag_fail, lock_fail};
	assign flag_clr = (dp_reg_wr_r && (dp_addr_r[7:0] == OFS_CLEAR)) ? ~HWDATA[2:0] : 3'h0;

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			flag_r <= 3'h0;
			irq_r  <= 1'b0;
		end
		else
		begin
			flag_r <= flag_set | (flag_r & ~flag_clr);
			irq_r  <= |(flag_r & ier_r);
		end
	end

	assign HRDATA    = hrdata_r;
	assign HREADYOUT = hreadyout_r;
	assign HRESP     = hresp_r;
	assign IRQ_FLASH = irq_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	err_resp_a: assert property (accept && misalign |=> HRESP && !HREADYOUT ##1 HRESP && HREADYOUT)
		else $error("misaligned access lacks two-cycle error");
	rd_wait0_a: assert property (bus_r == BS_RD && !busy && wait_r == 3'h0 |=> !HREADYOUT ##1 HREADYOUT)
		else $error("zero wait read wrong length");
	rd_wait2_a: assert property (bus_r == BS_RD && !busy && wait_r == 3'h2 |=> !HREADYOUT[*3] ##1 HREADYOUT)
		else $error("two wait read wrong length");
	fetch_stall_a: assert property (bus_r == BS_RD && busy |=> !HREADYOUT)
		else $error("read completed while busy");
	key_main_a: assert property (dp_reg_wr_r && dp_addr_r[7:0] == OFS_MAIN && !key_ok |=> $stable(mode_r))
		else $error("mode changed without key");
	key_lock_a: assert property (dp_reg_wr_r && dp_addr_r[7:0] != OFS_MAIN && !key_ok |=> $stable(lock_r))
		else $error("lock changed without key");
	lock_refuse_a: assert property (lock_fail |=> flag_r[FLG_LOCK] && op_r == OP_IDLE)
		else $error("locked page not refused");
	pc_refuse_a: assert property (pc_fail |=> flag_r[FLG_PC] && op_r == OP_IDLE)
		else $error("program counter page not refused");
	erase_fill_a: assert property (op_r == OP_ERASE |-> mem_we && mem_wdata == ERASED_WORD)
		else $error("erase did not write erased word");
	program_error_flag_land_a: assert property (op_r == OP_PROGRAM_ERROR_FLAG && !program_error_flag_fail |-> ((mem_wdata ^ op_data_r) & be_mask) == 32'h0)
		else $error("programmed lanes differ from write data");
	program_error_flag_err_a: assert property (program_error_flag_fail |=> flag_r[FLG_PROGRAM_ERROR_FLAG] && op_r == OP_IDLE)
		else $error("program error not flagged");
	busy_bit_a: assert property (start |=> busy [*2])
		else $error("busy not raised on start");
	irq_out_a: assert property (|(flag_r & ier_r) |=> IRQ_FLASH)
		else $error("interrupt not asserted");
	read_mode_a: assert property (dp_fl_wr_r && mode_r == MODE_READ |-> !start && flag_set == 3'h0)
		else $error("write in read mode had effect");

	erase_cv: cover property (start && mode_r == MODE_ERASE);
	program_error_flag_fail_cv: cover property (program_error_flag_fail);
	stall_cv: cover property (bus_r == BS_RD && busy);

endmodule : efepc_top

/* bench/efepc_host.sv */
module efepc_host
	import efepc_pkg::*;
(
	// Clock
	input  wire logic        CLK_SYS,
	// Bus master
	output logic             HSEL,
	output logic [31:0]      HADDR,
	output logic [1:0]       HTRANS,
	output logic             HWRITE,
	output logic [2:0]       HSIZE,
	output logic [31:0]      HWDATA,
	input  wire logic        HREADY,
	input  wire logic [31:0] HRDATA,
	input  wire logic        HRESP,
	// Core execution state
	output logic [31:0]      PC_ADDR,
	output logic             PC_IN_FLASH
);
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [31:0] A_MAIN = {REG_REGION, OFS_MAIN};
	localparam logic [31:0] A_LK0  = {REG_REGION, OFS_LOCK0};

	logic [31:0] rd_d;
	logic        rd_e;
	int          rd_n;

	initial
	begin
		HSEL        = 1'b0;
		HADDR       = 32'h0;
		HTRANS      = 2'h0;
		HWRITE      = 1'b0;
		HSIZE       = HSIZE_WORD;
		HWDATA      = 32'h0;
		PC_ADDR     = 32'h0;
		PC_IN_FLASH = 1'b0;
	end

	// ----------------------------------------------------------------
	// Single transfers
	// ----------------------------------------------------------------
	// Callers enter just after a rising edge; every bus signal change is non-blocking.
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [2:0] sz, input logic [31:0] wd);
		HSEL   <= 1'b1;
		HADDR  <= a;
		HTRANS <= 2'h2;
		HWRITE <= wr;
		HSIZE  <= sz;
		do
			@(posedge CLK_SYS);
		while (HREADY !== 1'b1);
		HSEL   <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= wd;
		rd_n = 0;
		do
		begin
			@(posedge CLK_SYS);
			rd_n++;
		end
		while (HREADY !== 1'b1);
		rd_d = HRDATA;
		rd_e = HRESP;
	endtask : xfer

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		xfer(1'b1, a, HSIZE_WORD, d);
	endtask : wr

	task automatic rd(input logic [31:0] a);
		xfer(1'b0, a, HSIZE_WORD, 32'h0);
	endtask : rd

	// ----------------------------------------------------------------
	// Software habits of the core
	// ----------------------------------------------------------------
	task automatic set_mode(input logic [1:0] m);
		wr(A_MAIN, {WR_KEY, 14'h0, m});
	endtask : set_mode

	task automatic set_lock0(input logic [15:0] v);
		wr(A_LK0, {WR_KEY, v});
	endtask : set_lock0

	// The bound keeps a stuck busy bit from hanging the run.
	task automatic wait_idle();
		for (int i = 0; i < 5000; i++)
		begin
			rd(A_MAIN);
			if (rd_d[MAIN_BUSY_BIT] === 1'b0)
				break;
		end
		tb_top.chk({31'h0, rd_d[MAIN_BUSY_BIT]}, 32'h0);
	endtask : wait_idle

	task automatic set_pc(input logic f, input logic [31:0] a);
		PC_IN_FLASH <= f;
		PC_ADDR     <= a;
	endtask : set_pc

endmodule : efepc_host

/* bench/tb_top.sv */
module tb_top;
	import efepc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Setup
	// ----------------------------------------------------------------
	// A short erase keeps the run brief; it stays above the floor.
	localparam int unsigned EC    = 200;
	localparam logic [31:0] A_MAIN = {REG_REGION, OFS_MAIN};
	localparam logic [31:0] A_TIM  = {REG_REGION, OFS_TIMING};
	localparam logic [31:0] A_LK3  = {REG_REGION, OFS_LOCK3};
	localparam logic [31:0] A_IER  = {REG_REGION, OFS_IER};
	localparam logic [31:0] A_FLG  = {REG_REGION, OFS_FLAG};
	localparam logic [31:0] A_CLR  = {REG_REGION, OFS_CLEAR};

	typedef struct packed {logic [7:0] ofs; logic [31:0] wd; logic [31:0] ex;} efepc_row_s;

	efepc_row_s rows [12] = '{
		'{OFS_TIMING, 32'h2, 32'h2}, '{OFS_MAIN, 32'h1, 32'h0},
		'{OFS_MAIN, {WR_KEY, 16'h1}, 32'h1}, '{OFS_MAIN, {WR_KEY, 16'h2}, 32'h2},
		'{OFS_MAIN, {WR_KEY, 16'h0}, 32'h0}, '{OFS_LOCK3, 32'h8000, 32'h0},
		'{OFS_LOCK3, {WR_KEY, 16'h8000}, 32'h8000}, '{OFS_LOCK3, {WR_KEY, 16'h0}, 32'h0},
		'{OFS_IER, 32'h7, 32'h7}, '{OFS_FLAG, 32'h7, 32'h0},
		'{OFS_CLEAR, 32'h0, 32'h7}, '{8'h40, 32'hffff_ffff, 32'h0}};

	logic        clk_sys = 1'b0;
	logic        rst     = 1'b1;
	logic        hsel, hwrite, hready, hresp, pc_f, irq;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, pc_a;
	int          bad_count       = 0;
	int          samples_checked = 0;

	always #2.5 clk_sys = ~clk_sys;

	efepc_top #(.ERASE_CYCLES(EC)) u_efepc_top (.CLK_SYS(clk_sys), .RST(rst), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
		.HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
		.PC_ADDR(pc_a), .PC_IN_FLASH(pc_f), .IRQ_FLASH(irq));

	efepc_host u_efepc_host (.CLK_SYS(clk_sys), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
		.HRESP(hresp), .PC_ADDR(pc_a), .PC_IN_FLASH(pc_f));

	// ----------------------------------------------------------------
	// Checking
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] ex);
		samples_checked++;
		if (got !== ex)
		begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, ex);
		end
	endtask : chk

	task automatic rdc(input logic [31:0] a, input logic [31:0] ex);
		u_efepc_host.rd(a);
		chk(u_efepc_host.rd_d, ex);
	endtask : rdc

	// Writing ones to the clear register first proves they do nothing.
	task automatic flg(input logic [31:0] ex, input logic [31:0] ie);
		u_efepc_host.wait_idle();
		u_efepc_host.wr(A_CLR, 32'h7);
		rdc(A_FLG, ex);
		chk({31'h0, irq}, {31'h0, |(ex & ie)});
		u_efepc_host.wr(A_CLR, 32'h0);
		rdc(A_FLG, 32'h0);
		chk({31'h0, irq}, 32'h0);
	endtask : flg

	task automatic stop_test();
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test

	initial
	begin
		#400us;
		bad_count++;
		stop_test();
	end

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		foreach (rows[i])
		begin
			u_efepc_host.wr({REG_REGION, rows[i].ofs}, rows[i].wd);
			rdc({REG_REGION, rows[i].ofs}, rows[i].ex);
		end
		u_efepc_host.set_mode(MODE_ERASE);
		u_efepc_host.wr(A_LK3, {WR_KEY, 16'h8000});
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rdc(A_MAIN, {30'h0, MODE_RST});
		rdc(A_TIM, {29'h0, WAIT_RST});
		rdc(A_IER, {29'h0, IER_RST});
		rdc(A_LK3, {16'h0, LOCK_RST[63:48]});
		chk({31'h0, irq}, 32'h0);
		u_efepc_host.wr(A_IER, 32'h7);
		u_efepc_host.set_mode(MODE_ERASE);
		u_efepc_host.set_lock0(16'h0001);
		u_efepc_host.wr(32'h104, 32'h0);
		u_efepc_host.rd(A_MAIN);
		chk({31'h0, u_efepc_host.rd_d[MAIN_BUSY_BIT]}, 32'h1);
		rdc(32'h1fc, ERASED_WORD);
		chk({31'h0, u_efepc_host.rd_n > 100}, 32'h1);
		rdc(32'h0, ERASED_WORD);
		for (int w = 0; w < 3; w++)
		begin
			u_efepc_host.wr(A_TIM, 32'(w));
			u_efepc_host.rd(32'h0);
			chk(32'(u_efepc_host.rd_n), 32'(3 + w));
		end
		u_efepc_host.set_mode(MODE_PROGRAM_ERROR_FLAG);
		u_efepc_host.wr(32'h4, 32'h1234_5678);
		u_efepc_host.wait_idle();
		rdc(32'h4, 32'h1234_5678);
		u_efepc_host.xfer(1'b1, 32'h9, HSIZE_BYTE, 32'h5555_5555);
		u_efepc_host.wait_idle();
		u_efepc_host.xfer(1'b1, 32'h8, HSIZE_BYTE, 32'h0);
		u_efepc_host.wait_idle();
		rdc(32'h8, 32'hffff_5500);
		u_efepc_host.xfer(1'b1, 32'h6, HSIZE_HALF, 32'hffff_ffff);
		flg(32'h2, 32'h7);
		rdc(32'h4, 32'h1234_5678);
		u_efepc_host.set_lock0(16'h0000);
		u_efepc_host.wr(32'hc, 32'h0);
		flg(32'h1, 32'h7);
		u_efepc_host.set_mode(MODE_ERASE);
		u_efepc_host.wr(32'h0, 32'h0);
		flg(32'h1, 32'h7);
		rdc(32'h4, 32'h1234_5678);
		u_efepc_host.wr(A_IER, 32'h3);
		u_efepc_host.set_lock0(16'h0001);
		u_efepc_host.set_pc(1'b1, 32'h40);
		u_efepc_host.wr(32'h0, 32'h0);
		flg(32'h4, 32'h3);
		u_efepc_host.set_mode(MODE_PROGRAM_ERROR_FLAG);
		u_efepc_host.wr(32'h10, 32'h0);
		flg(32'h4, 32'h3);
		rdc(32'h10, ERASED_WORD);
		u_efepc_host.set_pc(1'b0, 32'h0);
		u_efepc_host.set_lock0(16'h0000);
		u_efepc_host.set_mode(MODE_READ);
		u_efepc_host.wr(32'h8, 32'h0);
		rdc(32'h8, 32'hffff_5500);
		rdc(A_FLG, 32'h0);
		u_efepc_host.xfer(1'b1, 32'h2, HSIZE_WORD, 32'h0);
		chk({31'h0, u_efepc_host.rd_e}, 32'h1);
		u_efepc_host.xfer(1'b0, 32'h1, HSIZE_HALF, 32'h0);
		chk({31'h0, u_efepc_host.rd_e}, 32'h1);
		u_efepc_host.xfer(1'b0, 32'h2, HSIZE_HALF, 32'h0);
		chk({31'h0, u_efepc_host.rd_e}, 32'h0);
		u_efepc_host.xfer(1'b0, 32'h0, 3'h3, 32'h0);
		chk({31'h0, u_efepc_host.rd_e}, 32'h1);
		stop_test();
	end

endmodule : tb_top
